// *** rtl/tri_setup_cmd.sv ***
// Function
// - x step of 1/w adds left-to-right, subtracts right-to-left
// - fixed 1/w x gradient is signed 2.30, 32 bits
// - float gradient writes convert to the same internal fixed format
// - rgba y gradients add on positive y, subtract on negative y
// - fixed colour y gradient is low 24 bits, signed 12.12
// - depth y gradient adds on positive y, subtracts on negative y
// - fixed depth y gradient is signed 20.12, 32 bits
// - s/w and t/w y gradients add on positive y, subtract on negative
// - fixed s and t y gradients are signed 14.18, 32 bits
// - 1/w y gradient adds on positive y, subtracts on negative y
// - fixed 1/w y gradient is signed 2.30, 32 bits
// - write to either triangle command starts one triangle
// - command bit 31 clear means counter-clockwise, set means clockwise
// - only bit 31 of a triangle command is used
// - float triangle command takes orientation from the ieee sign bit
// - any write to the flush command flushes the pipeline
// - flush with bit 0 clears the five pixel statistics counters
// - flush with bit 1 clears the triangles-completed counter
// - flush with no clear bits leaves all counters unchanged
//
// Purpose: gradient setup registers, 1/w colour depth texture accumulators,
//   triangle and flush commands, statistics counters
// Assumes: single core clock, AHB-Lite slave with zero wait states
// Notes: accumulators start from zero at each triangle; start values are
//   added downstream
`timescale 1ns/10ps
module tri_setup_cmd (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [tri_setup_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire tri_setup_pkg::step_cmd_t step_cmd,
	input wire logic pipe_idle,
	input wire logic [tri_setup_pkg::NUM_STAT-1:0] stat_inc,
	output tri_setup_pkg::tri_cmd_t tri_cmd,
	output tri_setup_pkg::flush_cmd_t flush_cmd,
	output logic [tri_setup_pkg::NUM_ACC-1:0][31:0] acc_out
);

	// ==========================================================
	// float to fixed conversion
	function automatic logic [31:0] f2fix(
		input logic [31:0] f,
		input logic [4:0] frac,
		input logic narrow
	);
		logic [63:0] m;
		logic [31:0] lim;
		logic [31:0] mag;
		int sh;
		lim = narrow ? tri_setup_pkg::MAX_POS24 : tri_setup_pkg::MAX_POS32;
		m = {40'h0, 1'b1, f[22:0]};
		sh = int'(f[30:23]) - tri_setup_pkg::FP_BIAS_SHIFT + int'(frac);
		mag = 32'h0;
		// denormals flush to zero; too large saturates
		if (f[30:23] == 8'h00) begin
			mag = 32'h0;
		end else if (sh > tri_setup_pkg::FP_MAX_SHIFT) begin
			mag = lim;
		end else if (sh >= 0) begin
			m = m << sh;
			mag = (m > {32'h0, lim}) ? lim : m[31:0];
		end else if (sh > tri_setup_pkg::FP_MIN_SHIFT) begin
			m = m >> (-sh);
			mag = m[31:0];
		end
		return f[31] ? (32'h0 - mag) : mag;
	endfunction

	function automatic logic [4:0] frac_of(input int idx);
		logic [4:0] r;
		r = tri_setup_pkg::FRAC_ST;
		if (idx == tri_setup_pkg::G_WX) begin
			r = tri_setup_pkg::FRAC_WX;
		end else if (idx == tri_setup_pkg::G_WY) begin
			r = tri_setup_pkg::FRAC_WY;
		end else if (idx == tri_setup_pkg::G_Z) begin
			r = tri_setup_pkg::FRAC_Z;
		end else if (idx <= tri_setup_pkg::G_A) begin
			r = tri_setup_pkg::FRAC_COLOR;
		end
		return r;
	endfunction

	// ==========================================================
	// bus address phase capture
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [7:0] wr_addr_r;
	logic [7:0] wr_addr_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic addr_take;
	logic [7:0] a_addr;

	// whole-word transfers only; no wait states, so reads are
	// prepared in the address phase
	always_comb begin
		a_addr = 8'(haddr);
		addr_take = hsel && htrans[1] && hready;
		wr_pend_nxt = addr_take && hwrite;
		wr_addr_nxt = addr_take ? a_addr : wr_addr_r;
		rdata_nxt = 32'h0;
		if (addr_take && !hwrite) begin
			rdata_nxt = rd_word(a_addr);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r <= tri_setup_pkg::RST_WORD;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r <= rdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = rdata_r;

	// ==========================================================
	// gradient storage
	logic [tri_setup_pkg::NUM_GRAD-1:0][31:0] grad_r;
	logic [tri_setup_pkg::NUM_GRAD-1:0][31:0] grad_nxt;

	// a write lands at the edge that ends its data phase, before any
	// later command can act, so commands see earlier setup writes
	always_comb begin
		grad_nxt = grad_r;
		for (int i = 0; i < tri_setup_pkg::NUM_GRAD; i++) begin
			if (wr_pend_r && wr_addr_r == (tri_setup_pkg::OFS_GRAD_BASE + 8'(i * 8))) begin
				if (i >= tri_setup_pkg::G_R && i <= tri_setup_pkg::G_A) begin
					// colour takes low 24 bits, sign extended
					grad_nxt[i] = {{8{hwdata[tri_setup_pkg::COLOR_W-1]}}, hwdata[tri_setup_pkg::COLOR_W-1:0]};
				end else begin
					grad_nxt[i] = hwdata;
				end
			end
			if (wr_pend_r && wr_addr_r == (tri_setup_pkg::OFS_FLOAT_SEL + 8'(i * 8))) begin
				// float converted into the fixed layout
				grad_nxt[i] = f2fix(hwdata, frac_of(i), i >= tri_setup_pkg::G_R && i <= tri_setup_pkg::G_A);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			grad_r <= '0;
		end else begin
			grad_r <= grad_nxt;
		end
	end

	// ==========================================================
	// commands
	tri_setup_pkg::tri_cmd_t tri_nxt;
	tri_setup_pkg::flush_cmd_t flush_nxt;
	logic tri_wr;
	logic flush_wr;

	always_comb begin
		tri_wr = wr_pend_r && (wr_addr_r == tri_setup_pkg::OFS_TRI_FIXED || wr_addr_r == tri_setup_pkg::OFS_TRI_FLOAT);
		flush_wr = wr_pend_r && wr_addr_r == tri_setup_pkg::OFS_FLUSH_GO;
		// either command register starts a triangle
		tri_nxt.go = tri_wr;
		tri_nxt.cw = tri_cmd.cw;
		if (tri_wr) begin
			tri_nxt.cw = hwdata[tri_setup_pkg::TRI_SIGN_BIT];
		end
		flush_nxt.go = flush_wr;
		flush_nxt.clr = flush_wr ? hwdata[1:0] : 2'b00;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tri_cmd <= '0;
			flush_cmd <= '0;
		end else begin
			tri_cmd <= tri_nxt;
			flush_cmd <= flush_nxt;
		end
	end

	// ==========================================================
	// accumulators
	logic [tri_setup_pkg::NUM_ACC-1:0][31:0] acc_nxt;

	always_comb begin
		acc_nxt = acc_out;
		for (int k = 0; k < tri_setup_pkg::NUM_ACC; k++) begin
			if (tri_cmd.go) begin
				acc_nxt[k] = 32'h0;
			end else if (step_cmd.y_step) begin
				if (k == tri_setup_pkg::A_W) begin
					acc_nxt[k] = step_cmd.y_neg ? acc_nxt[k] - grad_r[tri_setup_pkg::G_WY]
						: acc_nxt[k] + grad_r[tri_setup_pkg::G_WY];
				end else begin
					acc_nxt[k] = step_cmd.y_neg ? acc_nxt[k] - grad_r[k] : acc_nxt[k] + grad_r[k];
				end
			end
		end
		// 1/w x step, direction by x_rtl
		if (!tri_cmd.go && step_cmd.x_step) begin
			acc_nxt[tri_setup_pkg::A_W] = step_cmd.x_rtl
				? acc_nxt[tri_setup_pkg::A_W] - grad_r[tri_setup_pkg::G_WX]
				: acc_nxt[tri_setup_pkg::A_W] + grad_r[tri_setup_pkg::G_WX];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			acc_out <= '0;
		end else begin
			acc_out <= acc_nxt;
		end
	end

	// ==========================================================
	// statistics counters
	logic [tri_setup_pkg::NUM_STAT-1:0][31:0] stat_r;
	logic [tri_setup_pkg::NUM_STAT-1:0][31:0] stat_nxt;

	generate
		for (genvar c = 0; c < tri_setup_pkg::NUM_STAT; c++) begin : g_stat
			logic clr;
			// pick the clear bit for this counter
			assign clr = (c == tri_setup_pkg::STAT_TRIS)
				? flush_cmd.clr[tri_setup_pkg::FLUSH_CLR_TRI_BIT]
				: flush_cmd.clr[tri_setup_pkg::FLUSH_CLR_PIX_BIT];
			// without its clear bit a counter only counts
			// clear wins over a same-cycle increment
			assign stat_nxt[c] = clr ? 32'h0 : (stat_r[c] + {31'h0, stat_inc[c]});
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			stat_r <= '0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// ==========================================================
	// read decode; command and gradient registers read as zero
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0;
		if (a == tri_setup_pkg::OFS_STATUS) begin
			r[tri_setup_pkg::ST_CW_BIT] = tri_cmd.cw;
			r[tri_setup_pkg::ST_BUSY_BIT] = !pipe_idle;
		end
		for (int c = 0; c < tri_setup_pkg::NUM_STAT; c++) begin
			if (a == tri_setup_pkg::OFS_STAT_BASE + 8'(c * 4)) begin
				r = stat_r[c];
			end
		end
		return r;
	endfunction

endmodule

// *** rtl/tri_setup_pkg.sv ***
// Purpose: shared constants and carriers for the triangle gradient setup block
// Assumes: AHB-Lite slave, 32-bit data, word-aligned registers
// Notes: gradient index selects one fixed/float register pair
package tri_setup_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_GRAD = 9;
	localparam int NUM_ACC = 8;
	localparam int NUM_STAT = 6;
	localparam int ADDR_W = 8;

	// ==========================================================
	// gradient indices (pair base = 8 * index)
	localparam int G_WX = 0;
	localparam int G_R = 1;
	localparam int G_G = 2;
	localparam int G_B = 3;
	localparam int G_A = 4;
	localparam int G_Z = 5;
	localparam int G_S = 6;
	localparam int G_T = 7;
	localparam int G_WY = 8;
	localparam int A_W = 0;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_GRAD_BASE = 8'h00;
	localparam logic [7:0] OFS_FLOAT_SEL = 8'h04;
	localparam logic [7:0] OFS_TRI_FIXED = 8'h48;
	localparam logic [7:0] OFS_TRI_FLOAT = 8'h4c;
	localparam logic [7:0] OFS_FLUSH_GO = 8'h50;
	localparam logic [7:0] OFS_STATUS = 8'h54;
	localparam logic [7:0] OFS_STAT_BASE = 8'h58;

	// ==========================================================
	// field positions
	localparam int TRI_SIGN_BIT = 31;
	localparam int FLUSH_CLR_PIX_BIT = 0;
	localparam int FLUSH_CLR_TRI_BIT = 1;
	localparam int STAT_TRIS = 5;
	localparam int ST_CW_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int COLOR_W = 24;

	// fractional bits per gradient index
	localparam logic [4:0] FRAC_WX = 5'h1e;
	localparam logic [4:0] FRAC_COLOR = 5'h0c;
	localparam logic [4:0] FRAC_Z = 5'h0c;
	localparam logic [4:0] FRAC_ST = 5'h12;
	localparam logic [4:0] FRAC_WY = 5'h1e;

	// ieee single layout
	localparam int FP_BIAS_SHIFT = 150;
	localparam int FP_MAX_SHIFT = 31;
	localparam int FP_MIN_SHIFT = -24;

	// ==========================================================
	// reset value and float saturation limits
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] MAX_POS32 = 32'h7fff_ffff;
	localparam logic [31:0] MAX_POS24 = 32'h007f_ffff;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic x_step;
		logic x_rtl;
		logic y_step;
		logic y_neg;
	} step_cmd_t;

	typedef struct packed {
		logic go;
		logic cw;
	} tri_cmd_t;

	typedef struct packed {
		logic go;
		logic [1:0] clr;
	} flush_cmd_t;

endpackage

// *** tb/tri_setup_cmd_sva.sv ***
// Purpose: port-level checks of the gradient setup block
// Assumes: single core clock, AHB-Lite zero wait
// Notes: command pulses land two edges after the address phase
`timescale 1ns/10ps
module tri_setup_cmd_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire tri_setup_pkg::step_cmd_t step_cmd,
	input wire tri_setup_pkg::tri_cmd_t tri_cmd,
	input wire tri_setup_pkg::flush_cmd_t flush_cmd,
	input wire logic [7:0][31:0] acc_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// taken writes
	wire tk = hsel & htrans[1] & hready & hwrite;
	wire wt = tk & (haddr == 8'h48 | haddr == 8'h4c);
	wire wf = tk & (haddr == 8'h50);
	// ==========================================
	// assertions
	a_tri_start: assert property (wt |-> ##2 tri_cmd.go)
		else $error("draw pulse missing");
	a_tri_cause: assert property (tri_cmd.go |-> $past(wt, 2))
		else $error("draw pulse without write");
	a_tri_sign: assert property (wt |=> ##1 tri_cmd.cw == $past(hwdata[31]))
		else $error("orientation wrong");
	a_flush_go: assert property (wf |-> ##2 flush_cmd.go)
		else $error("flush pulse missing");
	a_flush_bits: assert property (flush_cmd.go |-> flush_cmd.clr == $past(hwdata[1:0]))
		else $error("flush clear bits wrong");
	a_clr_idle: assert property (!flush_cmd.go |-> flush_cmd.clr == 2'h0)
		else $error("clear bits outside flush");
	a_acc_clear: assert property (tri_cmd.go |=> acc_out == '0)
		else $error("accumulators not cleared");
	a_acc_hold: assert property (!tri_cmd.go && !step_cmd.x_step && !step_cmd.y_step |=> $stable(acc_out))
		else $error("accumulator moved without step");
	a_bus_ready: assert property ($past(reset_n) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	c_cw: cover property (tri_cmd.go && tri_cmd.cw);
	c_clr: cover property (flush_cmd.go && flush_cmd.clr == 2'h3);
	c_yneg: cover property (step_cmd.y_step && step_cmd.y_neg);
endmodule
bind tri_setup_cmd tri_setup_cmd_chk tri_setup_cmd_chk_inst (.core_clk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .step_cmd, .tri_cmd, .flush_cmd, .acc_out);

// *** tb/tb_tri_setup_cmd.sv ***
// Purpose: directed bench for the gradient setup block
// Assumes: zero-wait slave, hready fed from hreadyout
// Notes: expected accumulators are hand-converted steps
`timescale 1ns/10ps
module tb_tri_setup_cmd;
	logic core_clk, reset_n, hsel, hwrite, pipe_idle, hreadyout, hresp;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	tri_setup_pkg::step_cmd_t step_cmd;
	tri_setup_pkg::tri_cmd_t tri_cmd;
	tri_setup_pkg::flush_cmd_t flush_cmd;
	logic [5:0] stat_inc;
	logic [7:0][31:0] acc_out;
	int fails, samples_checked;
	// one y step: 1/w, r, g, b, a, z, s, t
	localparam logic [31:0] EY[8] = '{32'hf000_0000, 32'hffff_f000, 32'h0000_1000, 32'h0000_2000,
		32'h0000_0800, 32'h0001_0000, 32'h0004_0000, 32'h0002_0000};
	tri_setup_cmd tri_setup_cmd_inst (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .step_cmd, .pipe_idle, .stat_inc,
		.tri_cmd, .flush_cmd, .acc_out);
	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ==========================================
	// helpers
	task final_report;
		$display("mismatches %0d of %0d checks", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task hw;
		int n;
		logic rdy;
		n = 0;
		do begin
			// sample where settled, away from the launching edge
			@(negedge core_clk);
			q = hrdata;
			rdy = hreadyout;
			@(posedge core_clk);
			n++;
		end while (rdy !== 1'b1 && n < 16);
		if (rdy !== 1'b1) begin
			ck(32'h0, 32'h1);
			final_report;
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hw;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		hw;
	endtask
	task stp(input logic [3:0] s);
		step_cmd <= s;
		@(posedge core_clk);
		step_cmd <= 4'h0;
		@(posedge core_clk);
	endtask
	task draw(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1, d);
		@(negedge core_clk);
		ck({tri_cmd.go, tri_cmd.cw}, {30'h0, 1'b1, d[31]});
		@(posedge core_clk);
	endtask
	task flush(input logic [1:0] d, input logic [31:0] e0, input logic [31:0] e5);
		xfer(8'h50, 1, {30'h0, d});
		@(negedge core_clk);
		ck({flush_cmd.go, flush_cmd.clr}, {29'h0, 1'b1, d});
		@(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			xfer(8'h58 + 8'(4 * i), 0, 32'h0);
			ck(q, i < 5 ? e0 : e5);
		end
	endtask
	// ==========================================
	// scenarios
	task t_x;
		xfer(8'h00, 1, 32'hc000_0001);
		draw(8'h48, 32'h0);
		stp(4'h8);
		ck(acc_out[0], 32'hc000_0001);
		stp(4'hc);
		ck(acc_out[0], 32'h0);
		xfer(8'h04, 1, 32'h3f80_0000);
		draw(8'h4c, 32'h0);
		stp(4'h8);
		ck(acc_out[0], 32'h4000_0000);
	endtask
	task t_y;
		xfer(8'h08, 1, 32'hab_fff000);
		xfer(8'h10, 1, 32'h0000_1000);
		xfer(8'h1c, 1, 32'h4000_0000);
		xfer(8'h20, 1, 32'h0000_0800);
		xfer(8'h28, 1, 32'h0001_0000);
		xfer(8'h30, 1, 32'h0004_0000);
		xfer(8'h3c, 1, 32'h3f00_0000);
		xfer(8'h44, 1, 32'hbe80_0000);
		draw(8'h48, 32'h7fff_ffff);
		stp(4'h2);
		for (int i = 0; i < 8; i++) ck(acc_out[i], EY[i]);
		stp(4'h3);
		for (int i = 0; i < 8; i++) ck(acc_out[i], 32'h0);
	endtask
	task t_orient;
		draw(8'h4c, 32'h8000_0001);
		xfer(8'h54, 0, 32'h0);
		ck(q[1:0], 2'h3);
		draw(8'h48, 32'h8000_0000);
		draw(8'h4c, 32'h3f80_0000);
		xfer(8'h7c, 0, 32'h0);
		ck(q, 32'h0);
		xfer(8'h00, 0, 32'h0);
		ck(q, 32'h0);
		pipe_idle <= 1;
		xfer(8'h54, 0, 32'h0);
		ck(q[1:0], 2'h0);
	endtask
	task t_stats;
		stat_inc <= 6'h3f;
		repeat (2) @(posedge core_clk);
		stat_inc <= 6'h0;
		@(posedge core_clk);
		flush(2'h0, 32'h2, 32'h2);
		flush(2'h1, 32'h0, 32'h2);
		flush(2'h2, 32'h0, 32'h0);
	endtask
	initial begin
		{reset_n, hsel, hwrite, haddr, htrans, hwdata, step_cmd, stat_inc} = '0;
		hsize = 3'h2;
		pipe_idle = 0;
		fails = 0;
		samples_checked = 0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1;
		repeat (2) @(posedge core_clk);
		t_x;
		t_y;
		t_orient;
		t_stats;
		final_report;
	end
endmodule
